// File: hdl/mie_defines.vh
/*
 * Constants of the instruction execute block: register byte offsets,
 * field positions, reset values, operation codes and memory sizes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef MIE_DEFINES_VH
`define MIE_DEFINES_VH

// register byte offsets on the AXI4-Lite bus
`define MIE_OFS_CTRL      8'h00
`define MIE_OFS_FLAGS     8'h04
`define MIE_OFS_ACC       8'h08
`define MIE_OFS_TABLE_POINTER_LOW   8'h0C
`define MIE_OFS_TABLE_POINTER_HIGH  8'h10
`define MIE_OFS_TABLE_HIGH_BYTE_REG 8'h14
`define MIE_OFS_CMD       8'h18
`define MIE_OFS_EXSTAT    8'h1C
`define MIE_OFS_RAM_ADDR  8'h20
`define MIE_OFS_RAM_DATA  8'h24
`define MIE_OFS_PM_ADDR   8'h28
`define MIE_OFS_PM_DATA   8'h2C

// flag bit positions in the flag register
`define MIE_FLG_C         0
`define MIE_FLG_AUXILIARY_CARRY 1
`define MIE_FLG_Z         2
`define MIE_FLG_OVERFLOW  3
`define MIE_FLG_SIGNED_COMPARE 4

// command word fields
`define MIE_CMD_OP_HI     4
`define MIE_CMD_OP_LO     0
`define MIE_CMD_BIT_HI    7
`define MIE_CMD_BIT_LO    5
`define MIE_CMD_ADR_HI    17
`define MIE_CMD_ADR_LO    8

// memory sizes
`define MIE_RAM_AW        10
`define MIE_RAM_WORDS     1024
`define MIE_PM_AW         12
`define MIE_PM_WORDS      4096
`define MIE_LAST_PAGE     4'hF

// reset values
`define MIE_RST_BYTE      8'h00
`define MIE_RST_FLAGS     5'h00
`define MIE_RST_CMD       18'h00000

// instruction cycles reported for a plain and for a skipping instruction
`define MIE_CYC_PLAIN     2'h1
`define MIE_CYC_SKIP      2'h2

// bus responses
`define MIE_RESP_OKAY     2'b00
`define MIE_RESP_SLVERR   2'b10

// operation codes
`define MIE_OP_SKIP_ZERO_MOVE_ACC        5'h00
`define MIE_OP_SZ_BIT     5'h01
`define MIE_OP_TABLE_READ_PAGE           5'h02
`define MIE_OP_TABLE_READ_LAST_PAGE      5'h03
`define MIE_OP_INCR_TABLE_READ_PAGE      5'h04
`define MIE_OP_INCR_TABLE_READ_LAST_PAGE 5'h05
`define MIE_OP_XOR_AM     5'h06
`define MIE_OP_XORM       5'h07
`define MIE_OP_XOR_AX     5'h08
`define MIE_OP_LADC       5'h09
`define MIE_OP_LADCM      5'h0A
`define MIE_OP_LADD       5'h0B
`define MIE_OP_LADDM      5'h0C
`define MIE_OP_LAND       5'h0D
`define MIE_OP_LANDM      5'h0E
`define MIE_OP_LCLR       5'h0F
`define MIE_OP_LCLR_BIT   5'h10
`define MIE_OP_LCPL       5'h11
`define MIE_OP_LCPLA      5'h12
`define MIE_OP_EXT_DECIMAL_ADJUST 5'h13
`define MIE_OP_LDEC       5'h14
`define MIE_OP_LDECA      5'h15
`define MIE_OP_LINC       5'h16
`define MIE_OP_LINCA      5'h17
`define MIE_OP_LMOV_AM    5'h18
`define MIE_OP_LMOV_MA    5'h19
`define MIE_OP_LOR        5'h1A
`define MIE_OP_LORM       5'h1B
`define MIE_OP_LRL        5'h1C
`define MIE_OP_LRLA       5'h1D

`endif

// File: hdl/mie_core.v
/*
 * Instruction execute block of an 8-bit core: skip, table read, XOR and
 * extended data memory instructions, reached over an AXI4-Lite slave.
 * Assumes one 125 MHz clock, synchronous active-low reset, and a master
 * that keeps one write and one read at most outstanding.
 */
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mie_defines.vh"
`default_nettype none

module mie_core (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_EXEC  = 2'd1;
  localparam [1:0] ST_DUMMY = 2'd2;

  reg  [7:0]               mem_q [0:`MIE_RAM_WORDS-1];
  reg  [15:0]              pm_q  [0:`MIE_PM_WORDS-1];
  reg  [1:0]               st_q;
  reg  [1:0]               bank_q;
  reg  [4:0]               flags_q;
  reg  [7:0]               acc_q;
  reg  [7:0]               table_pointer_low_q;
  reg  [7:0]               table_pointer_high_q;
  reg  [7:0]               table_high_byte_reg_q;
  reg  [17:0]              cmd_q;
  reg                      skip_q;
  reg  [1:0]               cycles_q;
  reg  [`MIE_RAM_AW-1:0]   ram_addr_q;
  reg  [`MIE_PM_AW-1:0]    pm_addr_q;
  reg                      aw_held_q;
  reg                      w_held_q;
  reg  [7:0]               awaddr_q;
  reg  [31:0]              wdata_q;
  reg  [3:0]               wstrb_q;

  ////////////////////////////////////////////////////////////////////////
  // command decode and datapath

  wire [4:0]             op      = cmd_q[`MIE_CMD_OP_HI:`MIE_CMD_OP_LO];
  wire [2:0]             bsel    = cmd_q[`MIE_CMD_BIT_HI:`MIE_CMD_BIT_LO];
  wire [9:0]             cmd_adr = cmd_q[`MIE_CMD_ADR_HI:`MIE_CMD_ADR_LO];
  wire                   is_ext  = (op >= `MIE_OP_LADC);
  // plain forms reach the selected section only; extended forms any section
  wire [`MIE_RAM_AW-1:0] ea      = is_ext ? cmd_adr : {bank_q, cmd_adr[7:0]};
  wire [7:0]             mv      = mem_q[ea];
  wire [7:0]             table_pointer_low_inc = table_pointer_low_q + 8'h01;
  wire                   c_in    = flags_q[`MIE_FLG_C];

  reg  [7:0]             res;
  reg                    to_acc;
  reg                    to_mem;
  reg                    skip;
  reg  [4:0]             fl;
  reg                    tab;
  reg  [7:0]             tp;
  reg  [`MIE_PM_AW-1:0]  pa;
  reg  [8:0]             sum;
  reg  [4:0]             lsum;
  reg  [8:0]             adj;

  always @* begin
    res    = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    skip   = 1'b0;
    fl     = flags_q;
    tab    = 1'b0;
    tp     = table_pointer_low_q;
    pa     = {table_pointer_high_q[3:0], table_pointer_low_q};
    sum    = 9'h000;
    lsum   = 5'h00;
    adj    = 9'h000;
    case (op)
      `MIE_OP_SKIP_ZERO_MOVE_ACC: begin
        res    = mv;
        to_acc = 1'b1;
        skip   = (mv == 8'h00);
      end
      `MIE_OP_SZ_BIT: begin
        skip = ~mv[bsel];
      end
      `MIE_OP_TABLE_READ_PAGE, `MIE_OP_TABLE_READ_LAST_PAGE,
      `MIE_OP_INCR_TABLE_READ_PAGE, `MIE_OP_INCR_TABLE_READ_LAST_PAGE: begin
        tab = 1'b1;
        // the increment forms address with the bumped pointer
        if (op == `MIE_OP_INCR_TABLE_READ_PAGE || op == `MIE_OP_INCR_TABLE_READ_LAST_PAGE)
          tp = table_pointer_low_inc;
        if (op == `MIE_OP_TABLE_READ_LAST_PAGE || op == `MIE_OP_INCR_TABLE_READ_LAST_PAGE)
          pa = {`MIE_LAST_PAGE, tp};
        else
          pa = {table_pointer_high_q[3:0], tp};
        res    = pm_q[pa][7:0];
        to_mem = 1'b1;
      end
      `MIE_OP_XOR_AM, `MIE_OP_XORM, `MIE_OP_XOR_AX: begin
        res = acc_q ^ ((op == `MIE_OP_XOR_AX) ? cmd_adr[7:0] : mv);
        to_acc = (op != `MIE_OP_XORM);
        to_mem = (op == `MIE_OP_XORM);
        fl[`MIE_FLG_Z] = (res == 8'h00);
      end
      `MIE_OP_LADC, `MIE_OP_LADCM, `MIE_OP_LADD, `MIE_OP_LADDM: begin
        if (op == `MIE_OP_LADC || op == `MIE_OP_LADCM) begin
          sum  = {1'b0, acc_q} + {1'b0, mv} + {8'h00, c_in};
          lsum = {1'b0, acc_q[3:0]} + {1'b0, mv[3:0]} + {4'h0, c_in};
        end else begin
          sum  = {1'b0, acc_q} + {1'b0, mv};
          lsum = {1'b0, acc_q[3:0]} + {1'b0, mv[3:0]};
        end
        res    = sum[7:0];
        to_acc = (op == `MIE_OP_LADC || op == `MIE_OP_LADD);
        to_mem = ~to_acc;
        fl[`MIE_FLG_C]  = sum[8];
        fl[`MIE_FLG_AUXILIARY_CARRY] = lsum[4];
        fl[`MIE_FLG_Z]  = (res == 8'h00);
        fl[`MIE_FLG_OVERFLOW] = (acc_q[7] == mv[7]) && (res[7] != acc_q[7]);
        // signed compare: true sign of the result despite overflow
        fl[`MIE_FLG_SIGNED_COMPARE] = fl[`MIE_FLG_OVERFLOW] ^ res[7];
      end
      `MIE_OP_LAND, `MIE_OP_LANDM: begin
        res    = acc_q & mv;
        to_acc = (op == `MIE_OP_LAND);
        to_mem = ~to_acc;
        fl[`MIE_FLG_Z] = (res == 8'h00);
      end
      `MIE_OP_LCLR: begin
        res    = 8'h00;
        to_mem = 1'b1;
      end
      `MIE_OP_LCLR_BIT: begin
        res       = mv;
        res[bsel] = 1'b0;
        to_mem    = 1'b1;
      end
      `MIE_OP_LCPL, `MIE_OP_LCPLA: begin
        res    = ~mv;
        to_acc = (op == `MIE_OP_LCPLA);
        to_mem = ~to_acc;
        fl[`MIE_FLG_Z] = (res == 8'h00);
      end
      `MIE_OP_EXT_DECIMAL_ADJUST: begin
        adj = {1'b0, acc_q};
        if (acc_q[3:0] > 4'h9 || flags_q[`MIE_FLG_AUXILIARY_CARRY])
          adj = adj + 9'h006;
        if (adj[7:4] > 4'h9 || c_in || adj[8])
          adj = adj + 9'h060;
        res    = adj[7:0];
        to_mem = 1'b1;
        if (adj[8] || (acc_q[7:4] > 4'h9))
          fl[`MIE_FLG_C] = 1'b1;
      end
      `MIE_OP_LDEC, `MIE_OP_LDECA: begin
        res    = mv - 8'h01;
        to_acc = (op == `MIE_OP_LDECA);
        to_mem = ~to_acc;
        fl[`MIE_FLG_Z] = (res == 8'h00);
      end
      `MIE_OP_LINC, `MIE_OP_LINCA: begin
        res    = mv + 8'h01;
        to_acc = (op == `MIE_OP_LINCA);
        to_mem = ~to_acc;
        fl[`MIE_FLG_Z] = (res == 8'h00);
      end
      `MIE_OP_LMOV_AM: begin
        res    = mv;
        to_acc = 1'b1;
      end
      `MIE_OP_LMOV_MA: begin
        res    = acc_q;
        to_mem = 1'b1;
      end
      `MIE_OP_LOR, `MIE_OP_LORM: begin
        res    = acc_q | mv;
        to_acc = (op == `MIE_OP_LOR);
        to_mem = ~to_acc;
        fl[`MIE_FLG_Z] = (res == 8'h00);
      end
      `MIE_OP_LRL, `MIE_OP_LRLA: begin
        res    = {mv[6:0], mv[7]};
        to_acc = (op == `MIE_OP_LRLA);
        to_mem = ~to_acc;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire       wr_fire = aw_held_q && w_held_q && !s_axi_bvalid && (st_q == ST_IDLE);
  wire [7:0] wa      = awaddr_q;
  wire       wr_map  = (wa[1:0] == 2'b00) && (wa <= `MIE_OFS_PM_DATA) &&
                       (wa != `MIE_OFS_TABLE_HIGH_BYTE_REG) && (wa != `MIE_OFS_EXSTAT);
  wire       wr_do   = wr_fire && wr_map && wstrb_q[0];
  wire       rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  reg [31:0] rd_val;
  reg        rd_ok;

  always @* begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `MIE_OFS_CTRL:     rd_val = {30'h00000000, bank_q};
      `MIE_OFS_FLAGS:    rd_val = {27'h0000000, flags_q};
      `MIE_OFS_ACC:      rd_val = {24'h000000, acc_q};
      `MIE_OFS_TABLE_POINTER_LOW: rd_val = {24'h000000, table_pointer_low_q};
      `MIE_OFS_TABLE_POINTER_HIGH: rd_val = {24'h000000, table_pointer_high_q};
      `MIE_OFS_TABLE_HIGH_BYTE_REG: rd_val = {24'h000000, table_high_byte_reg_q};
      `MIE_OFS_CMD:      rd_val = {14'h0000, cmd_q};
      `MIE_OFS_EXSTAT:   rd_val = {28'h0000000, cycles_q, skip_q, (st_q != ST_IDLE)};
      `MIE_OFS_RAM_ADDR: rd_val = {22'h000000, ram_addr_q};
      `MIE_OFS_RAM_DATA: rd_val = {24'h000000, mem_q[ram_addr_q]};
      `MIE_OFS_PM_ADDR:  rd_val = {20'h00000, pm_addr_q};
      `MIE_OFS_PM_DATA:  rd_val = {16'h0000, pm_q[pm_addr_q]};
      default:           rd_ok  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MIE_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `MIE_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core state; bus writes land only while idle, so no port collides

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= ST_IDLE;
      bank_q     <= 2'b00;
      flags_q    <= `MIE_RST_FLAGS;
      acc_q      <= `MIE_RST_BYTE;
      table_pointer_low_q   <= `MIE_RST_BYTE;
      table_pointer_high_q  <= `MIE_RST_BYTE;
      table_high_byte_reg_q <= `MIE_RST_BYTE;
      cmd_q      <= `MIE_RST_CMD;
      skip_q     <= 1'b0;
      cycles_q   <= 2'd0;
      ram_addr_q <= 10'h000;
      pm_addr_q  <= 12'h000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (wr_do) begin
            case (wa)
              `MIE_OFS_CTRL:     bank_q     <= wdata_q[1:0];
              `MIE_OFS_FLAGS:    flags_q    <= wdata_q[4:0];
              `MIE_OFS_ACC:      acc_q      <= wdata_q[7:0];
              `MIE_OFS_TABLE_POINTER_LOW:  table_pointer_low_q  <= wdata_q[7:0];
              `MIE_OFS_TABLE_POINTER_HIGH: table_pointer_high_q <= wdata_q[7:0];
              `MIE_OFS_RAM_ADDR: ram_addr_q <= wdata_q[9:0];
              `MIE_OFS_PM_ADDR:  pm_addr_q  <= wdata_q[11:0];
              `MIE_OFS_CMD: begin
                cmd_q <= wdata_q[17:0];
                st_q  <= ST_EXEC;
              end
              default: begin
                cmd_q <= cmd_q;
              end
            endcase
          end
        end
        ST_EXEC: begin
          flags_q  <= fl;
          skip_q   <= skip;
          if (to_acc)
            acc_q <= res;
          if (tab) begin
            table_high_byte_reg_q <= pm_q[pa][15:8];
            table_pointer_low_q   <= tp;
          end
          // a taken skip costs a dummy cycle while the next fetch happens
          if (skip) begin
            st_q     <= ST_DUMMY;
            cycles_q <= `MIE_CYC_SKIP;
          end else begin
            st_q     <= ST_IDLE;
            cycles_q <= `MIE_CYC_PLAIN;
          end
        end
        ST_DUMMY: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memories: no reset, software loads them through the data windows

  always @(posedge aclk) begin
    if (st_q == ST_EXEC && to_mem)
      mem_q[ea] <= res;
    else if (wr_do && wa == `MIE_OFS_RAM_DATA && st_q == ST_IDLE)
      mem_q[ram_addr_q] <= wdata_q[7:0];
  end

  always @(posedge aclk) begin
    if (wr_fire && wa == `MIE_OFS_PM_DATA && wstrb_q[0] && wstrb_q[1])
      pm_q[pm_addr_q] <= wdata_q[15:0];
  end

endmodule

`default_nettype wire

// File: tb/mie_axi_host.sv
/*
 * Host side of the register bus: an AXI4-Lite master that moves one word per call.
 * Assumes one clock and a caller that waits out reset before the first call.
 */
`timescale 1ns/1ps
`default_nettype none
module mie_axi_host (
  input  wire logic        aclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h00;
    arvalid = 1'h0;
    rready = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // address and data go out together; each is dropped at the edge its ready is seen
  task automatic write_word(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule
`default_nettype wire

// File: tb/mie_core_checker.sv
/*
 * Checker of the execute block: bus answer timing, refusals and status shape.
 * Assumes it sees only the core's ports; bound to mie_core below.
 */
`timescale 1ns/1ps
`include "mie_defines.vh"
`default_nettype none
module mie_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0] rd_adr_q;
  logic [7:0] wr_adr_q;
  // addresses are held by the master until taken, so the first cycle is enough
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      rd_adr_q <= s_axi_araddr;
    if (s_axi_awvalid && !s_axi_awready)
      wr_adr_q <= s_axi_awaddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  a_ar_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered next cycle");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  a_w_taken: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
    && !s_axi_wready && !s_axi_bvalid |=> s_axi_awready && s_axi_wready)
    else $error("write not taken next cycle");
  a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  a_cycles_skip: assert property (s_axi_rvalid && rd_adr_q == `MIE_OFS_EXSTAT
    |-> s_axi_rdata[1] == (s_axi_rdata[3:2] == 2'h2) && s_axi_rdata[31:4] == 28'h0)
    else $error("skip flag and cycle count disagree");
  a_bad_read: assert property (s_axi_rvalid && (rd_adr_q[1:0] != 2'h0
    || rd_adr_q > `MIE_OFS_PM_DATA) |-> s_axi_rresp == `MIE_RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_ro_write: assert property (s_axi_bvalid && (wr_adr_q == `MIE_OFS_TABLE_HIGH_BYTE_REG
    || wr_adr_q == `MIE_OFS_EXSTAT) |-> s_axi_bresp == `MIE_RESP_SLVERR)
    else $error("read-only write not refused");
endmodule
bind mie_core mie_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// File: tb/mcu_instruction_execute_tb_top.sv
/*
 * Testbench of the execute block: sets accumulator, data byte and flags over the
 * register bus, runs one instruction and compares every result.
 * Assumes mie_axi_host as bus master and the checker bound to the core.
 */
`timescale 1ns/1ps
`include "mie_defines.vh"
`default_nettype none
module mcu_instruction_execute_tb_top;
  localparam logic [9:0] MX = 10'h2A5;
  localparam logic [9:0] PL = 10'h134;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          num_errors = 0;
  int          checks_done = 0;
  always #4 aclk = ~aclk;
  mie_core u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  mie_axi_host u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    u_host.write_word(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    u_host.read_word(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // busy lasts one or two cycles, so a short bounded poll is plenty
  task automatic exec(input logic [31:0] c);
    logic [31:0] d;
    logic [1:0]  r;
    wr(`MIE_OFS_CMD, c);
    repeat (8) begin
      u_host.read_word(`MIE_OFS_EXSTAT, d, r);
      if (d[0] === 1'h0)
        break;
    end
  endtask
  // v = {acc in, byte in, acc out, byte out}, f = {flags in, flags out}, x = {bit, skip}
  task automatic run(input logic [4:0] op, input logic [9:0] ma, input logic [31:0] v,
                     input logic [15:0] f, input logic [7:0] x);
    wr(`MIE_OFS_ACC, {24'h0, v[31:24]});
    wr(`MIE_OFS_RAM_ADDR, {22'h0, ma});
    wr(`MIE_OFS_RAM_DATA, {24'h0, v[23:16]});
    wr(`MIE_OFS_FLAGS, {27'h0, f[12:8]});
    exec({14'h0, ma, x[6:4], op});
    rd(`MIE_OFS_ACC, {24'h0, v[15:8]});
    rd(`MIE_OFS_RAM_DATA, {24'h0, v[7:0]});
    rd(`MIE_OFS_FLAGS, {27'h0, f[4:0]});
    rd(`MIE_OFS_EXSTAT, x[0] ? 32'h0000000A : 32'h00000004);
  endtask
  task automatic tab(input logic [4:0] op, input logic [7:0] p0, input logic [7:0] p1,
                     input logic [15:0] w);
    wr(`MIE_OFS_TABLE_POINTER_LOW, {24'h0, p0});
    run(op, PL, {16'h00FF, 8'h00, w[7:0]}, 16'h1F1F, 8'h00);
    rd(`MIE_OFS_TABLE_HIGH_BYTE_REG, {24'h0, w[15:8]});
    rd(`MIE_OFS_TABLE_POINTER_LOW, {24'h0, p1});
  endtask
  task automatic pm(input logic [11:0] a, input logic [15:0] w);
    wr(`MIE_OFS_PM_ADDR, {20'h0, a});
    wr(`MIE_OFS_PM_DATA, {16'h0, w});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`MIE_OFS_FLAGS, 32'h0);
    rd(`MIE_OFS_ACC, 32'h0);
    rd(`MIE_OFS_EXSTAT, 32'h0);
    rd(8'h40, 32'h0, `MIE_RESP_SLVERR);
    wr(`MIE_OFS_EXSTAT, 32'h3, `MIE_RESP_SLVERR);
    wr(`MIE_OFS_TABLE_HIGH_BYTE_REG, 32'h55, `MIE_RESP_SLVERR);
    rd(`MIE_OFS_TABLE_HIGH_BYTE_REG, 32'h0);
    wr(`MIE_OFS_CTRL, 32'h1);
    run(`MIE_OP_SKIP_ZERO_MOVE_ACC, PL, 32'h55000000, 16'h1F1F, 8'h01);
    run(`MIE_OP_SKIP_ZERO_MOVE_ACC, PL, 32'h00808080, 16'h0000, 8'h00);
    run(`MIE_OP_SZ_BIT, PL, 32'h11F711F7, 16'h0404, 8'h31);
    run(`MIE_OP_SZ_BIT, PL, 32'h22802280, 16'h1B1B, 8'h70);
    run(`MIE_OP_XOR_AM, PL, 32'hF0FF0FFF, 16'h1B1B, 8'h00);
    run(`MIE_OP_XOR_AM, PL, 32'hA5A500A5, 16'h1B1F, 8'h00);
    run(`MIE_OP_XORM, PL, 32'h3C3C3C00, 16'h0004, 8'h00);
    run(`MIE_OP_XOR_AX, PL, 32'h35990199, 16'h0400, 8'h00);
    run(`MIE_OP_LADC, MX, 32'h7F008000, 16'h010A, 8'h00);
    run(`MIE_OP_LADCM, MX, 32'h80808001, 16'h0119, 8'h00);
    run(`MIE_OP_LADD, MX, 32'h88881088, 16'h011B, 8'h00);
    run(`MIE_OP_LADDM, MX, 32'h01FF0100, 16'h1F07, 8'h00);
    run(`MIE_OP_LAND, MX, 32'hF00F000F, 16'h1B1F, 8'h00);
    run(`MIE_OP_LANDM, MX, 32'hF03CF030, 16'h1F1B, 8'h00);
    run(`MIE_OP_LCLR, MX, 32'h66A56600, 16'h1B1B, 8'h00);
    run(`MIE_OP_LCLR_BIT, MX, 32'h00FF007F, 16'h0404, 8'h70);
    run(`MIE_OP_LCPL, MX, 32'h77FF7700, 16'h1B1F, 8'h00);
    run(`MIE_OP_LCPLA, MX, 32'h005AA55A, 16'h1F1B, 8'h00);
    run(`MIE_OP_EXT_DECIMAL_ADJUST, MX, 32'h9A449A00, 16'h0001, 8'h00);
    run(`MIE_OP_EXT_DECIMAL_ADJUST, MX, 32'h0800080E, 16'h0202, 8'h00);
    run(`MIE_OP_EXT_DECIMAL_ADJUST, MX, 32'h12001272, 16'h1D1D, 8'h00);
    run(`MIE_OP_LDEC, MX, 32'h55015500, 16'h1B1F, 8'h00);
    run(`MIE_OP_LDECA, MX, 32'h5500FF00, 16'h0400, 8'h00);
    run(`MIE_OP_LINC, MX, 32'h55FF5500, 16'h0004, 8'h00);
    run(`MIE_OP_LINCA, MX, 32'h007F807F, 16'h1F1B, 8'h00);
    run(`MIE_OP_LMOV_AM, MX, 32'hAA000000, 16'h0A0A, 8'h00);
    run(`MIE_OP_LMOV_MA, MX, 32'hC300C3C3, 16'h1515, 8'h00);
    run(`MIE_OP_LOR, MX, 32'h00000000, 16'h1B1F, 8'h00);
    run(`MIE_OP_LORM, MX, 32'h0FF00FFF, 16'h0400, 8'h00);
    run(`MIE_OP_LRL, MX, 32'h55815503, 16'h0000, 8'h00);
    run(`MIE_OP_LRLA, MX, 32'h00C081C0, 16'h1F1F, 8'h00);
    pm(12'h310, 16'hBEEF);
    pm(12'h30F, 16'hDEAD);
    pm(12'hF10, 16'h1234);
    pm(12'hF0F, 16'h5678);
    wr(`MIE_OFS_TABLE_POINTER_HIGH, 32'h3);
    tab(`MIE_OP_TABLE_READ_PAGE, 8'h10, 8'h10, 16'hBEEF);
    tab(`MIE_OP_TABLE_READ_LAST_PAGE, 8'h10, 8'h10, 16'h1234);
    tab(`MIE_OP_INCR_TABLE_READ_PAGE, 8'h0F, 8'h10, 16'hBEEF);
    tab(`MIE_OP_INCR_TABLE_READ_LAST_PAGE, 8'h0F, 8'h10, 16'h1234);
    print_verdict;
  end
  // thirty-five instructions of a dozen short transfers each fit well inside this
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("mismatch at %0t: watchdog ran out", $time);
    print_verdict;
  end
endmodule
`default_nettype wire
